/* File: battery_rail_select.sv */
// Two-channel battery rail selection with register port
`timescale 1ns/1ps
module battery_rail_select #(
  parameter int SAMPLE_W = rail_select_pkg::SAMPLE_W,
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // Line measurements, per channel, from the same clock domain
  input wire logic [NUM_CH-1:0] tipRingValid,
  input wire logic [NUM_CH*SAMPLE_W-1:0] tipRingVolt,
  input wire logic [NUM_CH-1:0] offHook,
  input wire logic [NUM_CH-1:0] ringActive,
  // Rail switch controls
  output logic [NUM_CH-1:0] railSelectOutput,
  output logic [NUM_CH-1:0] ringingRailOutput
);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0] relayCtrl_reg;
  logic [7:0] autoCtrl_reg;
  logic [15:0] highThr_reg [NUM_CH];
  logic [15:0] lowThr_reg [NUM_CH];
  logic [15:0] coef_reg [NUM_CH];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [NUM_CH-1:0] sel_reg;
  logic [NUM_CH-1:0] ring_reg;
  logic [NUM_CH-1:0] wantHigh;
  logic [SAMPLE_W-1:0] filtVolt [NUM_CH];

  logic autoEnable;
  logic manualRail;
  logic thirdRail;
  logic manualRing;

  assign autoEnable = autoCtrl_reg[rail_select_pkg::AUTO_ENABLE_BIT];
  assign manualRail = relayCtrl_reg[rail_select_pkg::RLY_MANUAL_RAIL_BIT];
  assign thirdRail = relayCtrl_reg[rail_select_pkg::RLY_THIRD_RAIL_BIT];
  assign manualRing = relayCtrl_reg[rail_select_pkg::RLY_RING_OUT_BIT];

  function automatic logic [7:0] chAddr(input logic [7:0] base,
                                        input int ch);
    chAddr = base + 8'(ch) * rail_select_pkg::CH_STRIDE;
  endfunction

  // Threshold field scaled to the filtered sample, as the comparator sees it
  function automatic logic [SAMPLE_W-1:0] thrLevel(input logic [15:0] thr);
    thrLevel = SAMPLE_W'(thr[rail_select_pkg::THR_MSB:
                             rail_select_pkg::THR_LSB])
               << rail_select_pkg::THR_LSB;
  endfunction

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic hitRelay;
  logic hitAuto;
  logic hitStatus;
  assign hitRelay = regAddr == rail_select_pkg::ADDR_RELAY_CTRL;
  assign hitAuto = regAddr == rail_select_pkg::ADDR_AUTO_CTRL;
  assign hitStatus = regAddr == rail_select_pkg::ADDR_RAIL_STATUS;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      relayCtrl_reg <= rail_select_pkg::RELAY_CTRL_RESET;
      autoCtrl_reg <= rail_select_pkg::AUTO_CTRL_RESET;
    end else if (regWrite) begin
      if (hitRelay) begin
        relayCtrl_reg <= regWdata[7:0];
      end
      if (hitAuto) begin
        autoCtrl_reg <= regWdata[7:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      logic hitHigh;
      logic hitLow;
      logic hitCoef;
      assign hitHigh = regAddr
                     == chAddr(rail_select_pkg::ADDR_HIGH_THR_CH0, g);
      assign hitLow = regAddr
                    == chAddr(rail_select_pkg::ADDR_LOW_THR_CH0, g);
      assign hitCoef = regAddr
                     == chAddr(rail_select_pkg::ADDR_FILT_COEF_CH0, g);

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          highThr_reg[g] <= rail_select_pkg::HIGH_THR_RESET;
          lowThr_reg[g] <= rail_select_pkg::LOW_THR_RESET;
          coef_reg[g] <= rail_select_pkg::FILT_COEF_RESET;
        end else if (regWrite) begin
          if (hitHigh) begin
            highThr_reg[g] <= regWdata;
          end
          if (hitLow) begin
            lowThr_reg[g] <= regWdata;
          end
          if (hitCoef) begin
            coef_reg[g] <= regWdata;
          end
        end
      end

      rail_lowpass #(
        .SAMPLE_W(SAMPLE_W)
      ) uFilt (
        .ref_clk(ref_clk),
        .rst(rst),
        .sampleValid(tipRingValid[g]),
        .sampleIn(tipRingVolt[g*SAMPLE_W +: SAMPLE_W]),
        .coef(coef_reg[g]),
        .filtOut(filtVolt[g])
      );

      rail_threshold #(
        .SAMPLE_W(SAMPLE_W)
      ) uThr (
        .ref_clk(ref_clk),
        .rst(rst),
        .filtVolt(filtVolt[g]),
        .highThr(highThr_reg[g]),
        .lowThr(lowThr_reg[g]),
        .wantHigh(wantHigh[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Rail decision
  // ---------------------------------------------------------------
  // On-hook keeps the high rail; off-hook follows the comparator.
  logic [NUM_CH-1:0] autoSel;
  logic [NUM_CH-1:0] selNext;
  logic [NUM_CH-1:0] ringNext;
  assign autoSel = ~offHook | wantHigh;
  assign selNext = autoEnable ? autoSel : {NUM_CH{manualRail}};
  // Ringing rail on while on-hook and ringing, dropped once off-hook
  assign ringNext = thirdRail ? (ringActive & ~offHook)
                              : {NUM_CH{manualRing}};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_reg <= '1;
      ring_reg <= '0;
    end else begin
      sel_reg <= selNext;
      ring_reg <= ringNext;
    end
  end

  assign railSelectOutput = sel_reg;
  assign ringingRailOutput = ring_reg;

  // ---------------------------------------------------------------
  // Register reads, one cycle latency; unmapped reads zero
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = '0;
    if (hitRelay) begin
      rdata_next = {8'h00, relayCtrl_reg};
    end
    if (hitAuto) begin
      rdata_next = {8'h00, autoCtrl_reg};
    end
    // Status width follows the channel count; extend on purpose
    if (hitStatus) begin
      rdata_next = 16'({ring_reg, sel_reg});
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (regAddr == chAddr(rail_select_pkg::ADDR_HIGH_THR_CH0, i)) begin
        rdata_next = highThr_reg[i];
      end
      if (regAddr == chAddr(rail_select_pkg::ADDR_LOW_THR_CH0, i)) begin
        rdata_next = lowThr_reg[i];
      end
      if (regAddr == chAddr(rail_select_pkg::ADDR_FILT_COEF_CH0, i)) begin
        rdata_next = coef_reg[i];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (regRead) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign regRdata = rdata_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_MANUAL_SEL: assert property (@(posedge ref_clk) disable iff (rst)
    !autoEnable |=> railSelectOutput == {NUM_CH{$past(manualRail)}})
    else $error("manual rail select not followed");

  AST_ONHOOK_HIGH: assert property (@(posedge ref_clk) disable iff (rst)
    (autoEnable && !offHook[0]) |=> railSelectOutput[0])
    else $error("on-hook channel 0 not on high rail");

  AST_OFFHOOK_FOLLOW: assert property (@(posedge ref_clk) disable iff (rst)
    (autoEnable && offHook[0] && !wantHigh[0]) |=> !railSelectOutput[0])
    else $error("off-hook channel 0 did not drop to low rail");

  AST_RING_AUTO: assert property (@(posedge ref_clk) disable iff (rst)
    (thirdRail && ringActive[0] && !offHook[0]) |=> ringingRailOutput[0])
    else $error("ringing rail not on during ringing");

  AST_RING_OFFHOOK: assert property (@(posedge ref_clk) disable iff (rst)
    (thirdRail && offHook[0]) |=> !ringingRailOutput[0])
    else $error("ringing rail held after off-hook");

  AST_RD_LATENCY: assert property (@(posedge ref_clk) disable iff (rst)
    (regRead && regAddr == rail_select_pkg::ADDR_RELAY_CTRL)
    |=> regRdata == {8'h00, $past(relayCtrl_reg)})
    else $error("relay control readback wrong");

  AST_RD_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
    !regRead |=> regRdata == 16'h0000)
    else $error("read data outside read slot");

  // Comparator may only rise past the high and fall past the low threshold
  AST_HYST_HOLD: assert property (
    @(posedge ref_clk) disable iff (rst)
    $rose(wantHigh[0])
    |-> $past(filtVolt[0]) > thrLevel($past(highThr_reg[0])))
    else $error("comparator rose without crossing high threshold");

  AST_HYST_FALL: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(wantHigh[0])
    |-> $past(filtVolt[0]) < thrLevel($past(lowThr_reg[0])))
    else $error("comparator fell without crossing low threshold");

  // Zero coefficient freezes the filter; unity passes the sample through
  AST_COEF_ZERO: assert property (
    @(posedge ref_clk) disable iff (rst)
    (tipRingValid[0] && coef_reg[0][rail_select_pkg::COEF_MSB:
                                    rail_select_pkg::COEF_LSB] == '0)
    |=> $stable(filtVolt[0]))
    else $error("zero coefficient let the filter move");

  AST_COEF_UNITY: assert property (
    @(posedge ref_clk) disable iff (rst)
    (tipRingValid[0] && coef_reg[0] == rail_select_pkg::COEF_UNITY)
    |=> filtVolt[0] == $past(tipRingVolt[SAMPLE_W-1:0]))
    else $error("unity coefficient did not pass the sample");

  AST_RING_MANUAL: assert property (
    @(posedge ref_clk) disable iff (rst)
    !thirdRail |=> ringingRailOutput == {NUM_CH{$past(manualRing)}})
    else $error("manual ringing output not followed");

  AST_WR_RELAY: assert property (
    @(posedge ref_clk) disable iff (rst)
    (regWrite && hitRelay) |=> relayCtrl_reg == $past(regWdata[7:0]))
    else $error("relay control write lost");

  // On-hook, off-hook and ringing-drop rules on every channel, not only the first
  for (genvar a = 0; a < NUM_CH; a++) begin : gChk
    AST_CH_ONHOOK: assert property (
      @(posedge ref_clk) disable iff (rst)
      (autoEnable && !offHook[a]) |=> railSelectOutput[a])
      else $error("on-hook channel not on high rail");

    AST_CH_OFFHOOK: assert property (
      @(posedge ref_clk) disable iff (rst)
      (autoEnable && offHook[a])
      |=> railSelectOutput[a] == $past(wantHigh[a]))
      else $error("off-hook channel not following comparator");

    AST_CH_RING: assert property (
      @(posedge ref_clk) disable iff (rst)
      (thirdRail && offHook[a]) |=> !ringingRailOutput[a])
      else $error("ringing rail held after off-hook");
  end

  COV_AUTO_LOW: cover property (@(posedge ref_clk)
    autoEnable && $fell(railSelectOutput[0]));
  COV_AUTO_HIGH: cover property (@(posedge ref_clk)
    autoEnable && $rose(railSelectOutput[0]));
  COV_RING: cover property (@(posedge ref_clk) $rose(ringingRailOutput[0]));
  COV_MANUAL: cover property (@(posedge ref_clk)
    !autoEnable && $changed(railSelectOutput));
  COV_RING_OFF: cover property (@(posedge ref_clk)
    thirdRail && $fell(ringingRailOutput[1]));

endmodule

/* File: rail_select_pkg.sv */
// Package: register map, field layout and constants for rail selection
package rail_select_pkg;

  // ---------------------------------------------------------------
  // Register addresses (8-bit register index space)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_RELAY_CTRL = 8'h05;
  localparam logic [7:0] ADDR_HIGH_THR_CH0 = 8'h10;
  localparam logic [7:0] ADDR_LOW_THR_CH0 = 8'h11;
  localparam logic [7:0] ADDR_FILT_COEF_CH0 = 8'h12;
  localparam logic [7:0] ADDR_HIGH_THR_CH1 = 8'h18;
  localparam logic [7:0] ADDR_LOW_THR_CH1 = 8'h19;
  localparam logic [7:0] ADDR_FILT_COEF_CH1 = 8'h1a;
  localparam logic [7:0] ADDR_AUTO_CTRL = 8'h20;
  localparam logic [7:0] ADDR_RAIL_STATUS = 8'h21;
  localparam logic [7:0] CH_STRIDE = 8'h08;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int RLY_MANUAL_RAIL_BIT = 5;
  localparam int RLY_THIRD_RAIL_BIT = 6;
  localparam int RLY_RING_OUT_BIT = 7;
  localparam int COEF_LSB = 3;
  localparam int COEF_MSB = 15;
  localparam int THR_LSB = 7;
  localparam int THR_MSB = 14;
  localparam int AUTO_ENABLE_BIT = 0;

  // ---------------------------------------------------------------
  // Reset values and filter scaling
  // ---------------------------------------------------------------
  localparam logic [7:0] RELAY_CTRL_RESET = 8'h00;
  localparam logic [15:0] HIGH_THR_RESET = 16'h0000;
  localparam logic [15:0] LOW_THR_RESET = 16'h0000;
  localparam logic [15:0] FILT_COEF_RESET = 16'h0a10;
  localparam logic [7:0] AUTO_CTRL_RESET = 8'h01;
  localparam logic [15:0] COEF_UNITY = 16'h4000;
  localparam int COEF_SHIFT = 14;
  localparam int SAMPLE_W = 16;

endpackage

/* File: rail_lowpass.sv */
// Single-pole low-pass filter on the tip-ring magnitude
`timescale 1ns/1ps
module rail_lowpass #(
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Sample stream
  input wire logic sampleValid,
  input wire logic [SAMPLE_W-1:0] sampleIn,
  input wire logic [15:0] coef,
  // Filtered result
  output logic [SAMPLE_W-1:0] filtOut
);

  // ---------------------------------------------------------------
  // y += k * (x - y), k = coef / 4000h
  // ---------------------------------------------------------------
  localparam int ACC_W = SAMPLE_W + rail_select_pkg::COEF_SHIFT;
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic signed [SAMPLE_W+1:0] diff;
  logic signed [SAMPLE_W+17:0] step;
  logic [15:0] coefMasked;

  // Low three bits are unused; above unity clamp so zero blocks, 4000h passes
  assign coefMasked = (coef & 16'hfff8) > rail_select_pkg::COEF_UNITY
                    ? rail_select_pkg::COEF_UNITY : (coef & 16'hfff8);
  assign diff = $signed({2'b00, sampleIn})
              - $signed({2'b00, acc_reg[ACC_W-1 -: SAMPLE_W]});
  assign step = diff * $signed({2'b00, coefMasked});
  assign acc_next = acc_reg + ACC_W'(step);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
    end else if (sampleValid) begin
      acc_reg <= acc_next;
    end
  end

  assign filtOut = acc_reg[ACC_W-1 -: SAMPLE_W];

endmodule

/* File: rail_threshold.sv */
// Hysteresis comparator choosing high or low rail for one channel
`timescale 1ns/1ps
module rail_threshold #(
  parameter int SAMPLE_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Filtered voltage and thresholds
  input wire logic [SAMPLE_W-1:0] filtVolt,
  input wire logic [15:0] highThr,
  input wire logic [15:0] lowThr,
  // Decision: 1 = high rail
  output logic wantHigh
);

  logic wantHigh_reg;
  logic [SAMPLE_W-1:0] highLevel;
  logic [SAMPLE_W-1:0] lowLevel;
  logic goHigh;
  logic goLow;

  // Only bits 14:7 are significant
  assign highLevel = SAMPLE_W'({highThr[rail_select_pkg::THR_MSB:
                     rail_select_pkg::THR_LSB], 7'h00});
  assign lowLevel = SAMPLE_W'({lowThr[rail_select_pkg::THR_MSB:
                    rail_select_pkg::THR_LSB], 7'h00});
  // Large tip-ring voltage means on-hook, needs the high rail
  assign goHigh = filtVolt > highLevel;
  assign goLow = filtVolt < lowLevel;

  // Hold the last choice between the two thresholds
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wantHigh_reg <= 1'b1;
    end else if (!wantHigh_reg && goHigh) begin
      wantHigh_reg <= 1'b1;
    end else if (wantHigh_reg && goLow) begin
      wantHigh_reg <= 1'b0;
    end
  end

  assign wantHigh = wantHigh_reg;

endmodule

/* File: line_model.sv */
// Line model: tip-ring samples seen by the rail selection block
`timescale 1ns/1ps
module line_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Loop state set by the bench
  input wire logic [15:0] loopVolt,
  // Samples to the block
  output logic [1:0] tipRingValid,
  output logic [31:0] tipRingVolt
);
  logic [1:0] divReg;
  wire strobe = (divReg == 2'h3);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divReg <= 2'h0;
    end else begin
      divReg <= divReg + 2'h1;
    end
  end
  // Between strobes the bus holds junk, so stale samples cannot pass
  assign tipRingValid = {2{strobe}};
  assign tipRingVolt = strobe ? {2{loopVolt}} : ~{2{loopVolt}};
endmodule

/* File: battery_rail_select_bench.sv */
// Self-checking bench for battery rail selection
`timescale 1ns/1ps
module battery_rail_select_bench;
  logic ref_clk;
  logic rst;
  logic [7:0] regAddr;
  logic [15:0] regWdata;
  logic [15:0] regRdata;
  logic [15:0] loopVolt;
  logic [15:0] rdVal;
  logic regWrite;
  logic regRead;
  logic [1:0] tipRingValid;
  logic [31:0] tipRingVolt;
  logic [1:0] offHook;
  logic [1:0] ringActive;
  logic [1:0] railSelectOutput;
  logic [1:0] ringingRailOutput;
  int fails;
  int checks;

  battery_rail_select DUT (.ref_clk(ref_clk), .rst(rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata),
    .tipRingValid(tipRingValid), .tipRingVolt(tipRingVolt),
    .offHook(offHook), .ringActive(ringActive),
    .railSelectOutput(railSelectOutput),
    .ringingRailOutput(ringingRailOutput));

  line_model line (.ref_clk(ref_clk), .rst(rst), .loopVolt(loopVolt),
    .tipRingValid(tipRingValid), .tipRingVolt(tipRingVolt));

  // -------------------------------------------------------------
  // Bus and compare helpers
  // -------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 rdVal = regRdata;
    chk(rdVal, e);
  endtask
  task automatic waitSel(input logic [1:0] e, input int lim);
    int n;
    n = 0;
    #1;
    while (railSelectOutput !== e && n < lim) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk({14'h0, railSelectOutput}, {14'h0, e});
    if (railSelectOutput !== e) begin
      conclude();
    end
  endtask
  task automatic holdSel(input logic [1:0] e);
    repeat (20) @(posedge ref_clk);
    #1 chk({14'h0, railSelectOutput}, {14'h0, e});
  endtask
  task automatic lineSet(input logic [1:0] oh, input logic [15:0] v);
    @(posedge ref_clk);
    offHook <= oh;
    loopVolt <= v;
  endtask
  task automatic setChan(input logic [15:0] hi, input logic [15:0] lo,
                         input logic [15:0] cf);
    logic [7:0] o;
    for (int c = 0; c < 2; c++) begin
      o = 8'(c) * rail_select_pkg::CH_STRIDE;
      wr(rail_select_pkg::ADDR_HIGH_THR_CH0 + o, hi);
      wr(rail_select_pkg::ADDR_LOW_THR_CH0 + o, lo);
      wr(rail_select_pkg::ADDR_FILT_COEF_CH0 + o, cf);
    end
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic testReset();
    chk({14'h0, railSelectOutput}, 16'h0003);
    chk({14'h0, ringingRailOutput}, 16'h0000);
    rchk(rail_select_pkg::ADDR_RELAY_CTRL, 16'h0000);
    rchk(rail_select_pkg::ADDR_AUTO_CTRL, 16'h0001);
    rchk(rail_select_pkg::ADDR_FILT_COEF_CH1, 16'h0a10);
    rchk(rail_select_pkg::ADDR_LOW_THR_CH0, 16'h0000);
    rchk(8'h7f, 16'h0000);
  endtask
  task automatic testManual();
    lineSet(2'b11, 16'h0c00);
    wr(rail_select_pkg::ADDR_AUTO_CTRL, 16'h0000);
    waitSel(2'b00, 8);
    wr(rail_select_pkg::ADDR_RELAY_CTRL, 16'h0020);
    waitSel(2'b11, 8);
    rchk(rail_select_pkg::ADDR_RELAY_CTRL, 16'h0020);
    wr(rail_select_pkg::ADDR_RELAY_CTRL, 16'h0000);
    wr(rail_select_pkg::ADDR_AUTO_CTRL, 16'h0001);
  endtask
  task automatic testAuto();
    // Stray bits outside 14:7 must not move the threshold
    setChan(16'h8a7f, 16'h0500, rail_select_pkg::COEF_UNITY);
    lineSet(2'b11, 16'h0400);
    waitSel(2'b00, 40);
    lineSet(2'b11, 16'h0800);
    holdSel(2'b00);
    lineSet(2'b11, 16'h0a40);
    waitSel(2'b11, 40);
    lineSet(2'b11, 16'h0800);
    holdSel(2'b11);
    lineSet(2'b11, 16'h0400);
    waitSel(2'b00, 40);
    lineSet(2'b01, 16'h0400);
    waitSel(2'b10, 8);
  endtask
  task automatic testCoef();
    lineSet(2'b11, 16'h0400);
    setChan(16'h0a00, 16'h0500, 16'h0007);
    lineSet(2'b11, 16'h0c00);
    holdSel(2'b00);
    setChan(16'h0a00, 16'h0500, 16'h0a10);
    repeat (8) @(posedge ref_clk);
    #1 chk({14'h0, railSelectOutput}, 16'h0000);
    waitSel(2'b11, 400);
  endtask
  task automatic testRing();
    lineSet(2'b00, 16'h0400);
    ringActive <= 2'b11;
    wr(rail_select_pkg::ADDR_RELAY_CTRL, 16'h0040);
    repeat (3) @(posedge ref_clk);
    #1 chk({14'h0, ringingRailOutput}, 16'h0003);
    lineSet(2'b10, 16'h0400);
    repeat (3) @(posedge ref_clk);
    #1 chk({14'h0, ringingRailOutput}, 16'h0001);
    ringActive <= 2'b00;
    wr(rail_select_pkg::ADDR_RELAY_CTRL, 16'h0080);
    waitSel(2'b01, 400);
    rchk(rail_select_pkg::ADDR_RAIL_STATUS, 16'h000d);
  endtask

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    regWrite = 1'b0;
    regRead = 1'b0;
    loopVolt = 16'h0c00;
    offHook = 2'b00;
    ringActive = 2'b00;
    fails = 0;
    checks = 0;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    testReset();
    testManual();
    testAuto();
    testCoef();
    testRing();
    conclude();
  end
endmodule
